// [rtl/bpa_fifo.sv]
// Parameterised valid/ready FIFO for duty words
module bpa_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_N = (AW+1)'(DEPTH);
	// Elaboration guard: pointer wrap needs a power-of-two depth
	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin
		$error("FIFO depth must be a power of two of at least 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_r;
	logic [AW:0] rdPtr_r;
	wire logic [AW:0] fill = wrPtr_r - rdPtr_r;
	wire logic doWr = inValid && inReady;
	wire logic doRd = outValid && outReady;
	assign inReady = fill != DEPTH_N;
	assign outValid = fill != '0;
	assign outData = mem[rdPtr_r[AW-1:0]];
	// Storage has no reset; only valid entries are ever read
	always_ff @(posedge sys_clk)
	begin
		if (doWr)
			mem[wrPtr_r[AW-1:0]] <= inData;
	end
	// Pointers with one extra bit to tell full from empty
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
		end
		else
		begin
			wrPtr_r <= wrPtr_r + (AW+1)'(doWr);
			rdPtr_r <= rdPtr_r + (AW+1)'(doRd);
		end
	end
endmodule

// [rtl/bpa_pkg.sv]
// Package for the buffered PWM audio output block
package bpa_pkg;
	// Operating clock and target rates
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned SAMPLE_HZ = 11_025;
	localparam int unsigned PWM_HZ = 100_000;
	// Period counts derived from the rates (counter runs 0..N-1)
	localparam int unsigned SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
	localparam int unsigned PWM_CYC = CLK_HZ / PWM_HZ;
	localparam int unsigned CNT_W = 16;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [CNT_W-1:0] DUTY_RST = 16'h0000;
	localparam logic PIN_RST = 1'b1;
	// Duty word travelling through the FIFO
	typedef struct packed {
		logic [CNT_W-1:0] duty;
	} bpa_sample_t;
endpackage

// [rtl/bpa_top.sv]
// Buffered PWM audio output: sample timer, duty FIFO, PWM channel
// Contract
// RULE_01: Sample channel counts freely, period ends at its first compare match.
// RULE_02: Sample channel pulses a tick each period; software supplies next duty then.
// RULE_03: PWM period ends on period compare match, which also clears counter.
// RULE_04: Configurer keeps PWM period shorter than sample period.
// RULE_05: Output pin goes low when counter matches active duty compare. A match at PWM_TOP keeps the pin high, since period match wins.
// RULE_06: Output pin goes high on period compare match, starting each cycle.
// RULE_07: Active duty compare is loaded only through the duty buffer register.
// RULE_08: Buffer copies into active compare only when the counter clears.
// RULE_09: Both channels count on the same operating clock.
// RULE_10: Software converts signed samples to duty counts before writing.
// RULE_11: PWM channel raises no interrupt of its own.
// RULE_12: Software keeps duty between zero and the period count.
// Limitation: an empty FIFO at a tick repeats the previous duty; underrun flags it.
module bpa_top #(
	parameter int CNT_W = bpa_pkg::CNT_W,
	parameter int SAMPLE_CYC = bpa_pkg::SAMPLE_CYC,
	parameter int PWM_CYC = bpa_pkg::PWM_CYC,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic dutyValid,
	output logic dutyReady,
	input wire bpa_pkg::bpa_sample_t dutyIn,
	output logic sampleTick,
	output logic pwmOut,
	output logic pwmOutEn,
	output logic underrun
);
	// Elaboration guard: fixed duty width, and a sample period longer than the PWM period
	if (CNT_W != bpa_pkg::CNT_W || PWM_CYC < 2 || SAMPLE_CYC <= PWM_CYC
		|| SAMPLE_CYC >= (1 << CNT_W))
	begin
		$error("Unsupported PWM or sample period setting");
	end
	localparam logic [CNT_W-1:0] SAMPLE_TOP = CNT_W'(SAMPLE_CYC - 1);
	localparam logic [CNT_W-1:0] PWM_TOP = CNT_W'(PWM_CYC - 1);

	// Sample-rate channel and PWM channel counters
	logic [CNT_W-1:0] sampleCnt_r;
	logic [CNT_W-1:0] channelUpCounter_r;
	logic [CNT_W-1:0] activeDutyCompare_r;
	logic [CNT_W-1:0] dutyBufferReg_r;
	logic bufFull_r;
	logic pwmOut_r;
	logic sampleTick_r;
	logic underrun_r;

	// Compare matches, all three counted on sys_clk
	wire logic sampleMatch = sampleCnt_r == SAMPLE_TOP; // see RULE_01 see RULE_09
	wire logic periodMatch = channelUpCounter_r == PWM_TOP; // see RULE_03
	wire logic dutyMatch = channelUpCounter_r == activeDutyCompare_r; // see RULE_05

	// Next values: each counter clears on its own match and otherwise steps by one
	wire logic [CNT_W-1:0] sampleCnt_nxt = sampleMatch ? bpa_pkg::CNT_RST
		: sampleCnt_r + 1'b1; // see RULE_01
	wire logic [CNT_W-1:0] channelUpCounter_nxt = periodMatch ? bpa_pkg::CNT_RST
		: channelUpCounter_r + 1'b1; // see RULE_03
	// Active compare reloads only at the counter clear, so duty never moves mid cycle
	wire logic [CNT_W-1:0] activeDutyCompare_nxt = periodMatch ? dutyBufferReg_r
		: activeDutyCompare_r; // see RULE_08
	// Period match wins so a duty of PWM_TOP still gives a high start
	wire logic pwmOut_nxt = periodMatch ? 1'b1 // see RULE_06
		: dutyMatch ? 1'b0 // see RULE_05
		: pwmOut_r;

	// FIFO feeds the buffer register one word per sample tick
	wire logic fifoValid;
	wire bpa_pkg::bpa_sample_t fifoData;
	wire logic fifoTake = sampleTick_r; // see RULE_02
	bpa_fifo #(
		.WIDTH($bits(bpa_pkg::bpa_sample_t)),
		.DEPTH(FIFO_DEPTH)
	) uFifo (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.inValid(dutyValid),
		.inReady(dutyReady),
		.inData(dutyIn),
		.outValid(fifoValid),
		.outReady(fifoTake),
		.outData(fifoData)
	);

	// Sample channel: free count, clear on first compare match
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sampleCnt_r <= bpa_pkg::CNT_RST;
			sampleTick_r <= 1'b0;
		end
		else
		begin
			sampleCnt_r <= sampleCnt_nxt; // see RULE_01
			sampleTick_r <= sampleMatch; // see RULE_02
		end
	end

	// Buffer register: only path into the active compare
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			dutyBufferReg_r <= bpa_pkg::DUTY_RST;
			underrun_r <= 1'b0;
		end
		else
		begin
			if (fifoTake && fifoValid)
				dutyBufferReg_r <= fifoData.duty; // see RULE_07
			// Empty FIFO at a tick keeps the old duty rather than glitching
			underrun_r <= fifoTake && !fifoValid;
		end
	end

	// PWM channel: clear on period match, transfer buffer at the clear
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			channelUpCounter_r <= bpa_pkg::CNT_RST;
			activeDutyCompare_r <= bpa_pkg::DUTY_RST;
			pwmOut_r <= bpa_pkg::PIN_RST;
		end
		else
		begin
			channelUpCounter_r <= channelUpCounter_nxt; // see RULE_03
			activeDutyCompare_r <= activeDutyCompare_nxt; // see RULE_08
			pwmOut_r <= pwmOut_nxt; // see RULE_05 see RULE_06
		end
	end

	// Registered outputs; the pin is driven at all times, so its enable is tied high
	assign sampleTick = sampleTick_r;
	assign pwmOut = pwmOut_r;
	assign pwmOutEn = 1'b1;
	assign underrun = underrun_r; // Status only; the PWM raises no interrupt, see RULE_11

	// Sample period is exact
	a_sample_period: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_01
		sampleMatch |=> sampleCnt_r == bpa_pkg::CNT_RST)
		else $error("Sample counter did not clear on its match");
	a_tick_follows: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_02
		sampleTick_r |-> $past(sampleCnt_r) == SAMPLE_TOP)
		else $error("Sample tick without a sample match");
	a_pwm_clear: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_03
		periodMatch |=> channelUpCounter_r == bpa_pkg::CNT_RST)
		else $error("PWM counter did not clear on period match");
	a_pin_low: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_05
		dutyMatch && !periodMatch |=> !pwmOut)
		else $error("Pin not low after duty match");
	a_pin_high: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_06
		periodMatch |=> pwmOut)
		else $error("Pin not high after period match");
	a_active_stable: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_08
		!$past(periodMatch) |-> $stable(activeDutyCompare_r))
		else $error("Active compare changed mid cycle");
	a_buffer_xfer: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_07
		periodMatch |=> activeDutyCompare_r == $past(dutyBufferReg_r))
		else $error("Buffer not copied at counter clear");
	a_same_clock: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_09
		!periodMatch && !sampleMatch |=>
		channelUpCounter_r == $past(channelUpCounter_r) + 1'b1
		&& sampleCnt_r == $past(sampleCnt_r) + 1'b1)
		else $error("Channels not counting together");

	// Helper for the assertions: cycles since the last tick, apart from the sample counter
	logic [CNT_W-1:0] tickGap_r;
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			tickGap_r <= bpa_pkg::CNT_RST;
		else
			tickGap_r <= sampleTick_r ? CNT_W'(1) : tickGap_r + 1'b1;
	end

	// Tick spacing measured independently of the sample counter
	a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_01
		sampleTick_r |-> tickGap_r == CNT_W'(SAMPLE_CYC))
		else $error("Sample ticks not one sample period apart");
	a_tick_single: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_02
		sampleTick_r |=> !sampleTick_r)
		else $error("Sample tick longer than one cycle");
	a_sample_range: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_01
		sampleCnt_r <= SAMPLE_TOP)
		else $error("Sample counter beyond its compare value");
	a_pwm_range: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_03
		channelUpCounter_r <= PWM_TOP)
		else $error("PWM counter beyond its period compare value");

	// Buffer moves only on a tick that finds a word; an empty FIFO keeps it
	a_buffer_load: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_07
		$changed(dutyBufferReg_r) |-> $past(fifoTake && fifoValid))
		else $error("Buffer register changed without a popped word");
	a_fifo_pop: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_02
		fifoTake && fifoValid |=> dutyBufferReg_r == $past(fifoData.duty))
		else $error("Popped word did not reach the buffer register");
	a_underrun_keep: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_07
		fifoTake && !fifoValid |=> $stable(dutyBufferReg_r) && underrun_r)
		else $error("Empty FIFO at a tick not flagged or duty lost");
	a_underrun_cause: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_02
		underrun_r |-> $past(fifoTake) && !$past(fifoValid))
		else $error("Underrun flagged without an empty tick");

	// Pin edges only at the two compare matches, and levels hold in between
	a_pin_fall: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_05
		$fell(pwmOut) |-> $past(dutyMatch) && !$past(periodMatch))
		else $error("Pin fell without a duty match");
	a_pin_rise: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_06
		$rose(pwmOut) |-> $past(periodMatch))
		else $error("Pin rose without a period match");
	a_low_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_06
		!pwmOut && !periodMatch |=> !pwmOut)
		else $error("Pin rose before the cycle end");
	a_high_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_05
		pwmOut && !dutyMatch |=> pwmOut)
		else $error("Pin fell before the duty match");
	a_full_duty: assert property (@(posedge sys_clk) disable iff (!nrst) // see RULE_06
		periodMatch && dutyBufferReg_r >= PWM_TOP |=> pwmOut ##1 pwmOut)
		else $error("Full duty did not keep the pin high");
endmodule

// [verif/bpa_filter_model.sv]
// Filter-side model: measures high time and period of the PWM pin
module bpa_filter_model (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic pwmIn,
	output int highCnt,
	output int periodCnt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic prev_r;
	int hi_r;
	int cyc_r;
	// Report once per rising edge, so a pin stuck at one level keeps the old figure
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
		begin
			prev_r <= 1'b1;
			hi_r <= 0;
			cyc_r <= 0;
			highCnt <= 0;
			periodCnt <= 0;
		end
		else
		begin
			prev_r <= pwmIn;
			if (pwmIn && !prev_r)
			begin
				highCnt <= hi_r;
				periodCnt <= cyc_r;
				hi_r <= 1;
				cyc_r <= 1;
			end
			else
			begin
				hi_r <= hi_r + (pwmIn ? 1 : 0);
				cyc_r <= cyc_r + 1;
			end
		end
endmodule

// [verif/tb_bpa_top.sv]
// Testbench for the buffered PWM audio output block
module tb_bpa_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PW = 8;
	localparam int SC = 40; // Sample period well above PW
	localparam shortint SAMP [3] = '{16'shE000, 16'sh4000, 16'sh8000};
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic dutyValid = 1'b0;
	bpa_pkg::bpa_sample_t dutyIn = '0;
	logic dutyReady, sampleTick, pwmOut, pwmOutEn, underrun;
	int highCnt, periodCnt, n;
	int fail_count = 0;
	int checks_done = 0;
	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;
	bpa_top #(.SAMPLE_CYC(SC), .PWM_CYC(PW)) uut (.sys_clk(sys_clk), .nrst(nrst),
		.dutyValid(dutyValid), .dutyReady(dutyReady), .dutyIn(dutyIn),
		.sampleTick(sampleTick), .pwmOut(pwmOut), .pwmOutEn(pwmOutEn), .underrun(underrun));
	bpa_filter_model flt (.sys_clk(sys_clk), .nrst(nrst), .pwmIn(pwmOut),
		.highCnt(highCnt), .periodCnt(periodCnt));
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD %s exp %0h seen %0h", what, exp, seen);
		end
	endtask
	task print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Bounded wait for a tick; a lost tick ends the run
	task wait_tick();
		n = 0;
		@(negedge sys_clk);
		while (sampleTick !== 1'b1 && n < 2 * SC)
		begin
			n++;
			@(negedge sys_clk);
		end
		if (n >= 2 * SC)
		begin
			check("tick timeout", 1, 0);
			print_verdict();
		end
	endtask
	// Reset levels, then release
	task t_reset();
		repeat (5) @(negedge sys_clk);
		check("rst pin", {pwmOut, pwmOutEn, sampleTick, underrun, dutyReady}, 5'h19);
		nrst = 1'b1;
	endtask
	// Tick spacing with empty FIFO; reset duty 0 gives one high cycle
	task t_tick();
		wait_tick();
		@(negedge sys_clk);
		check("underrun", underrun, 1);
		n = 1;
		while (sampleTick !== 1'b1 && n < 100)
		begin
			@(negedge sys_clk);
			n++;
		end
		check("tick period", n, SC);
		check("pwm period", periodCnt, PW);
		check("high time", highCnt, 1);
	endtask
	// Signed sample to duty count, as the feeding software does it
	function automatic logic [15:0] to_duty(input shortint s);
		return 16'(((int'(s) + 32'h0000_8000) * PW) >> 16);
	endfunction
	// Back-to-back words, each one takes effect only after its tick
	task t_duty();
		dutyValid = 1'b1;
		foreach (SAMP[i])
		begin
			dutyIn.duty = to_duty(SAMP[i]);
			@(negedge sys_clk);
		end
		dutyValid = 1'b0;
		foreach (SAMP[i])
		begin
			wait_tick();
			repeat (24) @(negedge sys_clk);
			check("duty high", highCnt, to_duty(SAMP[i]) + 1);
		end
	endtask
	// Fill until refused, then drain until the FIFO runs dry
	task t_fill();
		wait_tick();
		n = 0;
		dutyValid = 1'b1;
		while (dutyReady === 1'b1 && n < 20)
		begin
			dutyIn.duty = 16'(n % PW);
			@(negedge sys_clk);
			n++;
		end
		dutyValid = 1'b0;
		check("fifo depth", n, 16);
		repeat (16)
		begin
			wait_tick();
			@(negedge sys_clk);
			check("no underrun", {underrun, dutyReady}, 2'h1);
		end
		wait_tick();
		@(negedge sys_clk);
		check("dry underrun", underrun, 1);
	endtask
	initial
	begin
		t_reset();
		t_tick();
		t_duty();
		t_fill();
		print_verdict();
	end
endmodule
